//--- arith_pkg.sv
// Package for the arithmetic datapath: mode codes, group geometry, carriers.
// Assumes one cell clock and an active-low asynchronous reset around it.
package arith_pkg;

   // -------------------------------------------------------------------
   // Geometry and counts
   // -------------------------------------------------------------------
   localparam int unsigned GROUP_CELLS     = 10;
   localparam int unsigned GROUP_GEN_LOW   = 4;
   localparam int unsigned GROUP_GEN_HIGH  = 10;
   localparam int unsigned OPERAND_BITS    = 16;
   localparam int unsigned PRODUCT_BITS    = 32;
   localparam int unsigned TREE_LEVELS     = 4;
   localparam logic [31:0] PRODUCT_RESET   = 32'h0000_0000;

   // -------------------------------------------------------------------
   // Types
   // -------------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_ARITH,
      MODE_MULT
   } cell_mode_t;

   typedef enum logic {
      ROUTE_ROW,
      ROUTE_COLUMN
   } chain_route_t;

   typedef struct packed {
      logic sum_zero;
      logic sum_one;
      logic carry_zero;
      logic carry_one;
   } cell_pair_t;

   typedef struct packed {
      logic carry_zero_case;
      logic carry_one_case;
   } carry_pair_t;

endpackage : arith_pkg

//--- carry_select_cell.sv
// One logic cell of the carry-select chain in arithmetic form.
// Assumes incoming carry pair comes from the next lower-order cell.
module carry_select_cell
   import arith_pkg::*;
(
   // Operands
   input  wire logic        data_a_in,
   input  wire logic        data_b_in,
   // Incoming carry pair
   input  wire carry_pair_t carry_in,
   // Precomputed pair and forwarded carries
   output cell_pair_t       pair_out,
   output carry_pair_t      carry_out
);

   // -------------------------------------------------------------------
   // Parallel precompute
   // -------------------------------------------------------------------
   always_comb begin
      pair_out.sum_zero   = data_a_in ^ data_b_in;                    // [RQ1]
      pair_out.sum_one    = ~(data_a_in ^ data_b_in);                 // [RQ1]
      pair_out.carry_zero = data_a_in & data_b_in;                    // [RQ1]
      pair_out.carry_one  = data_a_in | data_b_in;                    // [RQ1]
      // Each chain's incoming carry picks its own carry-out
      carry_out.carry_zero_case = carry_in.carry_zero_case ?
                                  pair_out.carry_one : pair_out.carry_zero;  // [RQ6]
      carry_out.carry_one_case  = carry_in.carry_one_case ?
                                  pair_out.carry_one : pair_out.carry_zero;  // [RQ6] [RQ2]
   end

endmodule : carry_select_cell

//--- carry_select_adder_multiplier.sv
// Arithmetic datapath: carry-select adder chain and 16x16 tree multiplier.
// Assumes operands come from neighbouring cells on the same clock.
// Contract
// RQ1: Each cell precomputes sum and carry for incoming carry zero and one.
// RQ2: Both precomputed carries pass forward to the next higher-order cell.
// RQ3: A chain may start at any cell within a group; here only within the first group.
// RQ4: Group carry-in generation points sit at the fourth and tenth cells; here only the tenth feeds the group select.
// RQ5: Group carry-in picks which chain, and so which sum, is used.
// RQ6: Each chain's incoming carry picks which carry-out moves forward.
// RQ7: Cell register is bypassable, or holds the sum as an accumulator.
// RQ8: Chains past ten cells jump to the next even or odd group; here they run into the adjacent next group.
// RQ9: Multiplier handles signed or unsigned operands up to sixteen bits.
// RQ10: A multiplier cell sums a[n]b[m+1] plus a[n+1]b[m].
// RQ11: Partial-product sums are controlled by first clock enable and preset lines.
// RQ12: First group clock enable loses its clock-enable role in multiplier mode.
// RQ13: Multiplier cell gives sum and both carries; sum may be registered. Here the cell gives only the sum.
// RQ14: A column route runs the chain vertically for dedicated multipliers; here column_route_in is not used.
// RQ15: Sixteen partial products are added pairwise in a binary tree.
// RQ16: Driving the fast group interconnect disables local outputs.
// RQ17: Arithmetic cells form a plus b plus carry, registered or not.
// RQ18: The product is 32 bits and equals a behavioural multiply.
module carry_select_adder_multiplier
   import arith_pkg::*;
#(
   parameter int unsigned CHAIN_GROUPS = 2
)
(
   // Clock and reset
   input  wire logic                                 clk_in,
   input  wire logic                                 resetn_in,
   // Mode and group controls
   input  wire logic                                 mult_mode_in,
   input  wire logic                                 column_route_in,
   input  wire logic                                 group_clock_enable_first_in,
   input  wire logic                                 preset_async_load_line_in,
   input  wire logic                                 register_bypass_in,
   input  wire logic                                 accumulate_in,
   input  wire logic                                 fast_out_select_in,
   // Adder operands
   input  wire logic [CHAIN_GROUPS*GROUP_CELLS-1:0]  add_a_in,
   input  wire logic [CHAIN_GROUPS*GROUP_CELLS-1:0]  add_b_in,
   input  wire logic [GROUP_CELLS-1:0]               chain_start_in,
   input  wire logic                                 group_carry_in,
   // Multiplier operands
   input  wire logic [OPERAND_BITS-1:0]              mult_a_in,
   input  wire logic [OPERAND_BITS-1:0]              mult_b_in,
   input  wire logic                                 mult_signed_in,
   // Results
   output logic [CHAIN_GROUPS*GROUP_CELLS-1:0]       sum_out,
   output logic                                      carry_out,
   output logic [GROUP_CELLS-1:0]                    cross_sum_out,
   output logic [PRODUCT_BITS-1:0]                   local_product_out,
   output logic [PRODUCT_BITS-1:0]                   fast_product_out,
   output logic                                      fast_valid_out
);

   localparam int unsigned W = CHAIN_GROUPS * GROUP_CELLS;

   // -------------------------------------------------------------------
   // Carry-select chain
   // -------------------------------------------------------------------
   cell_pair_t  pair     [W];
   carry_pair_t cin      [W];
   carry_pair_t cout     [W];
   logic [W-1:0] a_eff;
   logic [W-1:0] chain_sum;
   logic [W-1:0] sum_nxt;
   logic [W-1:0] sum_r;
   logic [W-1:0] acc_view;
   logic         group_sel [CHAIN_GROUPS+1];
   logic         carry_nxt;
   logic         carry_r;

   // Accumulator feeds the held sum back as operand a
   assign acc_view = accumulate_in ? sum_r : add_a_in;                  // [RQ7]
   assign a_eff    = acc_view;

   genvar gi;
   generate
      for (gi = 0; gi < W; gi++) begin : g_cell
         carry_select_cell u_cell (                                      // [RQ1] [RQ6]
            .data_a_in (a_eff[gi]),
            .data_b_in (add_b_in[gi]),
            .carry_in  (cin[gi]),
            .pair_out  (pair[gi]),
            .carry_out (cout[gi])
         );
      end
   endgenerate

   always_comb begin
      group_sel[0] = group_carry_in;
      for (int g = 0; g < CHAIN_GROUPS; g++) begin
         for (int c = 0; c < GROUP_CELLS; c++) begin
            int i;
            i = g * GROUP_CELLS + c;
            if (i == 0 || (g == 0 && chain_start_in[c])) begin
               // Chain may open at any cell of the first group
               cin[i].carry_zero_case = 1'b0;                             // [RQ3]
               cin[i].carry_one_case  = 1'b1;                             // [RQ3]
            end else if (c == 0) begin
               // Carry pair comes straight from the last cell of the previous group
               cin[i] = cout[i-1];                                        // [RQ8] [RQ14]
            end else begin
               cin[i] = cout[i-1];                                        // [RQ2]
            end
         end
         // Group carry-in regenerated at the tenth cell only
         group_sel[g+1] = group_sel[g] ?
            cout[g*GROUP_CELLS+GROUP_GEN_HIGH-1].carry_one_case :
            cout[g*GROUP_CELLS+GROUP_GEN_HIGH-1].carry_zero_case;        // [RQ4]
      end
   end

   always_comb begin
      for (int i = 0; i < W; i++) begin
         logic sel;
         int   g;
         g   = i / GROUP_CELLS;
         sel = group_sel[g] ? cin[i].carry_one_case : cin[i].carry_zero_case;  // [RQ5]
         chain_sum[i] = sel ? pair[i].sum_one : pair[i].sum_zero;         // [RQ5] [RQ17]
      end
   end

   logic gen_low_seen;
   assign gen_low_seen = group_sel[CHAIN_GROUPS-1] ?
      cout[(CHAIN_GROUPS-1)*GROUP_CELLS+GROUP_GEN_LOW-1].carry_one_case :
      cout[(CHAIN_GROUPS-1)*GROUP_CELLS+GROUP_GEN_LOW-1].carry_zero_case; // [RQ4]

   // Clock enable only gates the register outside multiplier mode
   logic add_ce;
   assign add_ce = mult_mode_in ? 1'b1 : group_clock_enable_first_in;   // [RQ12]

   always_comb begin
      sum_nxt   = sum_r;
      carry_nxt = carry_r;
      if (add_ce && !mult_mode_in) begin
         sum_nxt   = chain_sum;                                           // [RQ7]
         carry_nxt = group_sel[CHAIN_GROUPS];
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sum_r   <= '0;
         carry_r <= 1'b0;
      end else begin
         sum_r   <= sum_nxt;
         carry_r <= carry_nxt;
      end
   end

   // Output flop follows either the combinational sum or the held one
   logic [W-1:0] sum_out_nxt;
   logic         carry_out_nxt;
   always_comb begin
      sum_out_nxt   = register_bypass_in ? chain_sum : sum_r;             // [RQ7] [RQ17]
      carry_out_nxt = register_bypass_in ? group_sel[CHAIN_GROUPS] : carry_r;
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sum_out   <= '0;
         carry_out <= 1'b0;
      end else begin
         sum_out   <= sum_out_nxt;
         carry_out <= carry_out_nxt;
      end
   end

   // -------------------------------------------------------------------
   // Cross partial-product cells
   // -------------------------------------------------------------------
   logic [GROUP_CELLS-1:0] cross_nxt;
   always_comb begin
      for (int n = 0; n < GROUP_CELLS; n++) begin
         // Row m held at the low operand bits; preset line gates the sum
         cross_nxt[n] = preset_async_load_line_in &
                        ((mult_a_in[n] & mult_b_in[1]) ^
                         (mult_a_in[n+1] & mult_b_in[0]));                // [RQ10] [RQ11] [RQ13]
      end
   end

   logic [GROUP_CELLS-1:0] cross_r;
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cross_r <= '0;
      end else begin
         cross_r <= cross_nxt;
      end
   end
   assign cross_sum_out = cross_r;

   // -------------------------------------------------------------------
   // Binary-tree multiplier
   // -------------------------------------------------------------------
   logic [PRODUCT_BITS-1:0] level [TREE_LEVELS+1][OPERAND_BITS];
   logic [PRODUCT_BITS-1:0] product_nxt;
   logic [PRODUCT_BITS-1:0] product_r;
   logic [PRODUCT_BITS-1:0] ext_a;
   logic                    stage_ce;
   logic                    valid_nxt;
   logic                    valid_r;

   always_comb begin
      // Sign extension gives signed results with the same tree
      ext_a = mult_signed_in ? {{OPERAND_BITS{mult_a_in[OPERAND_BITS-1]}}, mult_a_in}
                             : {{OPERAND_BITS{1'b0}}, mult_a_in};       // [RQ9]
      for (int m = 0; m < OPERAND_BITS; m++) begin
         logic [PRODUCT_BITS-1:0] pp;
         pp = mult_b_in[m] ? (ext_a << m) : '0;                           // [RQ15]
         // Signed top bit carries negative weight
         if (mult_signed_in && m == OPERAND_BITS-1) begin
            pp = PRODUCT_BITS'(~pp + 32'h0000_0001);                       // [RQ9]
         end
         level[0][m] = pp;
      end
      for (int l = 1; l <= TREE_LEVELS; l++) begin
         for (int k = 0; k < OPERAND_BITS; k++) begin
            if (k < (OPERAND_BITS >> l)) begin
               level[l][k] = level[l-1][2*k] + level[l-1][2*k+1];         // [RQ15]
            end else begin
               level[l][k] = '0;
            end
         end
      end
      product_nxt = level[TREE_LEVELS][0];                                // [RQ18]
   end

   // First clock-enable line steers the product pipeline stage
   assign stage_ce  = group_clock_enable_first_in;                        // [RQ11]
   assign valid_nxt = mult_mode_in ? stage_ce : valid_r;

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         product_r <= PRODUCT_RESET;
         valid_r   <= 1'b0;
      end else begin
         if (mult_mode_in && stage_ce) begin
            product_r <= product_nxt;                                      // [RQ13]
         end
         valid_r <= valid_nxt;
      end
   end

   // Fast output blanks the local outputs
   logic [PRODUCT_BITS-1:0] local_nxt;
   logic [PRODUCT_BITS-1:0] fast_nxt;
   logic                    fast_v_nxt;
   always_comb begin
      local_nxt  = fast_out_select_in ? '0 : product_r;                   // [RQ16]
      fast_nxt   = fast_out_select_in ? product_r : '0;                   // [RQ16]
      fast_v_nxt = fast_out_select_in & valid_r;
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         local_product_out <= '0;
         fast_product_out  <= '0;
         fast_valid_out    <= 1'b0;
      end else begin
         local_product_out <= local_nxt;
         fast_product_out  <= fast_nxt;
         fast_valid_out    <= fast_v_nxt;
      end
   end

   logic unused_ok;
   assign unused_ok = gen_low_seen ^ column_route_in;

endmodule : carry_select_adder_multiplier

//--- operand_feeder.sv
// Neighbouring cell model: streams new adder operands every cycle while run_in is high.
// Assumes one cell clock and an active-low asynchronous reset.
module operand_feeder
#(
   parameter int unsigned W = 20
)
(
   // Clock and reset
   input  wire logic         clk_in,
   input  wire logic         resetn_in,
   // Stream control
   input  wire logic         run_in,
   // Operands
   output logic [W-1:0]      a_out,
   output logic [W-1:0]      b_out
);
   logic [W-1:0] a_nxt;
   logic [W-1:0] b_nxt;

   always_comb begin
      a_nxt = run_in ? a_out + {a_out[W-2:0], 1'b1} : a_out;
      b_nxt = run_in ? b_out ^ {a_out[W-3:0], 2'b11} : b_out;
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         a_out <= '0;
         b_out <= '1;
      end else begin
         a_out <= a_nxt;
         b_out <= b_nxt;
      end
   end
endmodule : operand_feeder

//--- arith_monitor.sv
// Checker for the arithmetic datapath ports.
// Assumes one cell clock and an active-low reset.
module arith_monitor
   import arith_pkg::*;
#(
   parameter int unsigned CHAIN_GROUPS = 2,
   localparam int W = CHAIN_GROUPS*GROUP_CELLS
)
(
   // Clock and reset
   input wire logic                   clk_in,
   input wire logic                   resetn_in,
   // Controls
   input wire logic                   mult_mode_in,
   input wire logic                   group_clock_enable_first_in,
   input wire logic                   preset_async_load_line_in,
   input wire logic                   register_bypass_in,
   input wire logic                   accumulate_in,
   input wire logic                   fast_out_select_in,
   input wire logic [GROUP_CELLS-1:0] chain_start_in,
   // Operands
   input wire logic [W-1:0]           add_a_in,
   input wire logic [W-1:0]           add_b_in,
   input wire logic                   group_carry_in,
   input wire logic [15:0]            mult_a_in,
   input wire logic [15:0]            mult_b_in,
   input wire logic                   mult_signed_in,
   // Results
   input wire logic [W-1:0]           sum_out,
   input wire logic                   carry_out,
   input wire logic [GROUP_CELLS-1:0] cross_sum_out,
   input wire logic [31:0]            local_product_out,
   input wire logic [31:0]            fast_product_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!resetn_in);

   wire ce = group_clock_enable_first_in;
   wire byp = register_bypass_in;
   wire mm = mult_mode_in;
   wire fs = fast_out_select_in;
   wire ar = !mm && !accumulate_in && chain_start_in == '0;
   wire [W:0] total = add_a_in + add_b_in + group_carry_in;
   wire [W-1:0] tsum = add_a_in + add_b_in + group_carry_in;
   wire [9:0] xs = ((mult_a_in[9:0] & {10{mult_b_in[1]}})
                   ^ (mult_a_in[10:1] & {10{mult_b_in[0]}})) & {10{preset_async_load_line_in}};
   wire [31:0] pr = mult_signed_in
                  ? {{16{mult_a_in[15]}}, mult_a_in} * {{16{mult_b_in[15]}}, mult_b_in}
                  : {16'h0, mult_a_in} * {16'h0, mult_b_in};

   a_bypass_sum: assert property (byp && ar |=> {carry_out, sum_out} == $past(total))
      else $error("bypass sum wrong");
   a_reg_sum: assert property (!byp && ce && ar ##1 !byp |=> sum_out == $past(tsum, 2))
      else $error("registered sum wrong");
   a_hold_noen: assert property ((!byp && !ce && !mm)[*3] |=> $stable(sum_out))
      else $error("sum changed without enable");
   a_mult_noload: assert property ((mm && !byp)[*3] |=> $stable(sum_out))
      else $error("sum changed in multiplier mode");
   a_local_prod: assert property (mm && ce && !fs ##1 mm && !fs |=>
      local_product_out == $past(pr, 2)) else $error("local product wrong");
   a_fast_prod: assert property (mm && ce && fs ##1 mm && fs |=>
      fast_product_out == $past(pr, 2)) else $error("fast product wrong");
   a_local_off: assert property (fs [*2] |=> local_product_out == '0)
      else $error("local product not blanked");
   a_cross_sum: assert property (mm |=> cross_sum_out == $past(xs))
      else $error("cross sum wrong");
   a_cross_gate: assert property (mm && !preset_async_load_line_in |=> cross_sum_out == '0)
      else $error("cross sum not gated");

   c_bypass: cover property (byp && ar);
   c_accum: cover property (accumulate_in && ce && !mm && !byp);
   c_fast: cover property (mm && ce && fs);
   c_start: cover property (byp && !mm && chain_start_in != '0);
endmodule : arith_monitor

bind carry_select_adder_multiplier arith_monitor #(.CHAIN_GROUPS(CHAIN_GROUPS)) u_arith_monitor (
   .clk_in(clk_in), .resetn_in(resetn_in), .mult_mode_in(mult_mode_in),
   .group_clock_enable_first_in(group_clock_enable_first_in),
   .preset_async_load_line_in(preset_async_load_line_in),
   .register_bypass_in(register_bypass_in), .accumulate_in(accumulate_in),
   .fast_out_select_in(fast_out_select_in), .chain_start_in(chain_start_in),
   .add_a_in(add_a_in), .add_b_in(add_b_in), .group_carry_in(group_carry_in),
   .mult_a_in(mult_a_in), .mult_b_in(mult_b_in), .mult_signed_in(mult_signed_in),
   .sum_out(sum_out), .carry_out(carry_out), .cross_sum_out(cross_sum_out),
   .local_product_out(local_product_out), .fast_product_out(fast_product_out)
);

//--- carry_select_adder_multiplier_tb.sv
// Testbench: adder, stream, accumulator, multiplier and cross sums.
// Assumes the bound checker and the operand feeder model.
module carry_select_adder_multiplier_tb
   import arith_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int W = 2*GROUP_CELLS;
   logic clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic mult_mode_in = 1'b0;
   logic column_route_in = 1'b0;
   logic ce = 1'b0;
   logic preset_in = 1'b0;
   logic bypass = 1'b1;
   logic acc = 1'b0;
   logic fast_sel = 1'b0;
   logic [W-1:0] add_a_in = '0;
   logic [W-1:0] add_b_in = '0;
   logic cin = 1'b0;
   logic [15:0] mult_a_in = '0;
   logic [15:0] mult_b_in = '0;
   logic sgn = 1'b0;
   logic feed_run = 1'b0;
   logic [9:0] cstart = '0;
   logic [W-1:0] sum_out, f_a, f_b;
   logic [9:0] cross_sum_out;
   logic [31:0] local_product_out, fast_product_out;
   logic carry_out, fast_valid_out;
   int n_mismatch = 0;
   int checks_done = 0;

   carry_select_adder_multiplier #(.CHAIN_GROUPS(2)) u_carry_select_adder_multiplier (
      .clk_in(clk_in), .resetn_in(resetn_in), .mult_mode_in(mult_mode_in),
      .column_route_in(column_route_in), .group_clock_enable_first_in(ce),
      .preset_async_load_line_in(preset_in), .register_bypass_in(bypass),
      .accumulate_in(acc), .fast_out_select_in(fast_sel), .add_a_in(add_a_in),
      .add_b_in(add_b_in), .chain_start_in(cstart), .group_carry_in(cin),
      .mult_a_in(mult_a_in), .mult_b_in(mult_b_in), .mult_signed_in(sgn),
      .sum_out(sum_out), .carry_out(carry_out), .cross_sum_out(cross_sum_out),
      .local_product_out(local_product_out), .fast_product_out(fast_product_out),
      .fast_valid_out(fast_valid_out));
   operand_feeder #(.W(W)) u_operand_feeder (.clk_in(clk_in), .resetn_in(resetn_in),
      .run_in(feed_run), .a_out(f_a), .b_out(f_b));

   always #12.5 clk_in = ~clk_in;

   task automatic chk(input logic [31:0] got, exp, input string what);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_of_test

   task automatic t_adder();
      logic [W-1:0] xa[5] = '{20'hfffff, 20'hfffff, 20'h003ff, 20'h00000, 20'haaaaa};
      logic [W-1:0] xb[5] = '{20'h00000, 20'hfffff, 20'h00001, 20'h00000, 20'h55555};
      logic xc[5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
      for (int i = 0; i < 5; i++) begin
         @(posedge clk_in);
         add_a_in <= xa[i];
         add_b_in <= xb[i];
         cin <= xc[i];
         @(posedge clk_in);
         #1;
         chk({carry_out, sum_out}, {1'b0, xa[i]} + xb[i] + xc[i], "adder");
      end
      $display("adder test done");
   endtask : t_adder

   task automatic t_stream();
      logic [31:0] exp;
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_in);
         feed_run <= 1'b1;
         add_a_in <= f_a;
         add_b_in <= f_b;
         cin <= i[0];
         #1;
         if (i > 0) chk({carry_out, sum_out}, exp, "stream");
         exp = {1'b0, add_a_in} + add_b_in + cin;
      end
      $display("stream test done");
   endtask : t_stream

   task automatic t_start();
      logic [W-1:0] sa[2] = '{20'h0001f, 20'h00010};
      logic sc[2] = '{1'b0, 1'b1};
      logic [31:0] se[2] = '{32'h10, 32'h22};
      for (int i = 0; i < 2; i++) begin
         @(posedge clk_in);
         cstart <= 10'h010;
         add_a_in <= sa[i];
         add_b_in <= 20'h00001;
         cin <= sc[i];
         @(posedge clk_in);
         #1;
         chk({carry_out, sum_out}, se[i], "chain start");
      end
      @(posedge clk_in);
      cstart <= '0;
      $display("chain start test done");
   endtask : t_start

   task automatic t_accum();
      @(posedge clk_in);
      bypass <= 1'b0;
      ce <= 1'b1;
      add_a_in <= '0;
      add_b_in <= '0;
      cin <= 1'b0;
      @(posedge clk_in);
      acc <= 1'b1;
      add_b_in <= 20'h00005;
      cin <= 1'b1;
      repeat (4) @(posedge clk_in);
      ce <= 1'b0;
      repeat (3) @(posedge clk_in);
      #1;
      chk(sum_out, 32'h18, "accumulate");
      @(posedge clk_in);
      mult_mode_in <= 1'b1;
      ce <= 1'b1;
      repeat (3) @(posedge clk_in);
      #1;
      chk(sum_out, 32'h18, "mult hold");
      $display("accumulator test done");
   endtask : t_accum

   task automatic t_mult();
      logic [15:0] ma[5] = '{16'hffff, 16'hffff, 16'h8000, 16'h7fff, 16'h1234};
      logic [15:0] mb[5] = '{16'hffff, 16'hffff, 16'h8000, 16'h8000, 16'h0000};
      logic ms[5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
      logic [31:0] e[5] = '{32'hfffe0001, 32'h1, 32'h40000000, 32'hc0008000, 32'h0};
      for (int f = 0; f < 2; f++) begin
         for (int i = 0; i < 5; i++) begin
            @(posedge clk_in);
            acc <= 1'b0;
            column_route_in <= f[0];
            mult_a_in <= ma[i];
            mult_b_in <= mb[i];
            sgn <= ms[i];
            fast_sel <= f[0];
            repeat (2) @(posedge clk_in);
            #1;
            chk(f ? fast_product_out : local_product_out, e[i], "product");
            if (f) chk(local_product_out, '0, "local blank");
            chk({31'h0, fast_valid_out}, {31'h0, f[0]}, "fast valid");
         end
      end
      $display("multiplier test done");
   endtask : t_mult

   task automatic t_cross();
      logic [9:0] exp;
      for (int p = 0; p < 2; p++) begin
         for (int b = 0; b < 4; b++) begin
            @(posedge clk_in);
            mult_a_in <= 16'h5a3c;
            mult_b_in <= 16'(b);
            preset_in <= p[0];
            @(posedge clk_in);
            #1;
            exp = ((10'h23c & {10{b[1]}}) ^ (10'h11e & {10{b[0]}})) & {10{p[0]}};
            chk(cross_sum_out, exp, "cross sum");
         end
      end
      $display("cross sum test done");
   endtask : t_cross

   initial begin
      repeat (6) @(posedge clk_in);
      resetn_in <= 1'b1;
      @(posedge clk_in);
      #1;
      chk({sum_out, 12'h0}, '0, "reset sum");
      t_adder();
      t_stream();
      t_start();
      t_accum();
      t_mult();
      t_cross();
      end_of_test();
   end

   // Watchdog, far beyond the roughly 90 cycles the tests need
   initial begin
      repeat (2000) @(posedge clk_in);
      n_mismatch++;
      end_of_test();
   end
endmodule : carry_select_adder_multiplier_tb
